// ===== gpt_pkg.sv
package gpt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] GPT_TIMER_STRIDE = 8'h20;
  localparam logic [7:0] GPT_OFF_CTRL = 8'h00;
  localparam logic [7:0] GPT_OFF_REF = 8'h04;
  localparam logic [7:0] GPT_OFF_CAPTURE = 8'h08;
  localparam logic [7:0] GPT_OFF_COUNT = 8'h0C;
  localparam logic [7:0] GPT_OFF_IRQ_STATUS = 8'h40;
  localparam logic [7:0] GPT_OFF_IRQ_ENABLE = 8'h44;
  localparam logic [7:0] GPT_OFF_IRQ_CLEAR = 8'h48;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int GPT_CTRL_MODE_LSB = 0;
  localparam int GPT_CTRL_CLK_SEL = 2;
  localparam int GPT_CTRL_REF_IRQ = 3;
  localparam int GPT_CTRL_TOGGLE = 4;
  localparam int GPT_CTRL_EDGE_LSB = 5;
  localparam int GPT_CTRL_PRESCALE_LSB = 8;
  localparam int GPT_CTRL_WIDTH = 16;
  localparam logic [15:0] GPT_CTRL_RESET = 16'h0000;
  localparam logic [15:0] GPT_REF_RESET = 16'hFFFF;

  // Status bits per timer: capture event, reference event
  localparam int GPT_ST_CAPTURE = 0;
  localparam int GPT_ST_REF = 1;
  localparam int GPT_ST_PER_TIMER = 2;
  localparam int GPT_NUM_TIMERS = 2;
  localparam int GPT_ST_WIDTH = 4;

  typedef enum logic [1:0] {
    GPT_MODE_OFF = 2'b00,
    GPT_MODE_CAPTURE = 2'b01,
    GPT_MODE_REFERENCE = 2'b11,
    GPT_MODE_EVENT = 2'b10
  } gpt_mode_e;

endpackage

// ===== gpt_timer.sv
`timescale 1ns/1ns
module gpt_timer import gpt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire gpt_mode_e mode,
  input wire logic clk_sel,
  input wire logic ref_irq_sel,
  input wire logic out_toggle,
  input wire logic [1:0] edge_sel,
  input wire logic [7:0] prescale,
  input wire logic [15:0] ref_value,
  input wire logic external_timer_clock_in,
  input wire logic ext_event,
  output logic [15:0] count,
  output logic [15:0] capture,
  output logic capture_pulse,
  output logic ref_irq_pulse,
  output logic timer_out
);

  // ----------------------------------------------------------------
  // Edge detection and tick generation
  // ----------------------------------------------------------------
  logic ext_clk_d;
  logic ext_event_d;
  logic [7:0] pre_cnt;
  logic src_tick;
  logic pre_tick;
  logic ev_hit;
  logic advance;
  logic ref_hit;
  logic [15:0] next_count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_d <= 1'b0;
      ext_event_d <= 1'b0;
    end else begin
      ext_clk_d <= external_timer_clock_in;
      ext_event_d <= ext_event;
    end
  end

  assign ev_hit = (edge_sel[0] & ext_event & ~ext_event_d) | (edge_sel[1] & ~ext_event & ext_event_d);
  assign src_tick = clk_sel ? (external_timer_clock_in & ~ext_clk_d) : 1'b1;
  assign pre_tick = (mode != GPT_MODE_OFF) && src_tick && (pre_cnt == prescale);
  // Prescaler divides by prescale+1 so a value of zero still counts
  assign advance = (mode == GPT_MODE_EVENT) ? ev_hit : pre_tick;
  assign next_count = count + 16'h0001;
  assign ref_hit = (mode == GPT_MODE_REFERENCE) && advance && (next_count == ref_value);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 8'h00;
    end else if (mode == GPT_MODE_OFF) begin
      pre_cnt <= 8'h00;
    end else if (src_tick) begin
      pre_cnt <= (pre_cnt == prescale) ? 8'h00 : pre_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counter, capture and reference
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (mode == GPT_MODE_OFF) begin
      count <= 16'h0000;
    end else if (advance) begin
      count <= next_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= 16'h0000;
      capture_pulse <= 1'b0;
    end else begin
      capture_pulse <= (mode == GPT_MODE_CAPTURE) && ev_hit;
      if ((mode == GPT_MODE_CAPTURE) && ev_hit) begin
        capture <= count;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_irq_pulse <= 1'b0;
      timer_out <= 1'b1;
    end else begin
      ref_irq_pulse <= ref_hit & ref_irq_sel;
      if (ref_hit && !ref_irq_sel) begin
        timer_out <= out_toggle ? ~timer_out : 1'b0;
      end else if (!out_toggle) begin
        // Pulse mode: low for exactly one clock, then back to idle high
        timer_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_capture_value;
    @(posedge pclk) disable iff (!presetn)
      ((mode == GPT_MODE_CAPTURE) && ev_hit) |=> (capture == $past(count)) && capture_pulse;
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("capture missed counter value");

  property p_pulse_low;
    @(posedge pclk) disable iff (!presetn)
      (ref_hit && !ref_irq_sel && !out_toggle) |=> !timer_out ##1 timer_out;
  endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("output pulse not one clock low");

  property p_toggle;
    @(posedge pclk) disable iff (!presetn)
      (ref_hit && !ref_irq_sel && out_toggle) |=> (timer_out != $past(timer_out));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_ref_irq;
    @(posedge pclk) disable iff (!presetn)
      (ref_hit && ref_irq_sel) |=> ref_irq_pulse && $stable(timer_out);
  endproperty
  a_ref_irq: assert property (p_ref_irq) else $error("reference interrupt path wrong");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (advance && (count == 16'hFFFF) && (mode != GPT_MODE_OFF)) |=> (count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_event_count;
    @(posedge pclk) disable iff (!presetn)
      ((mode == GPT_MODE_EVENT) && !ev_hit) |=> (count == $past(count));
  endproperty
  a_event_count: assert property (p_event_count) else $error("event counter moved without event");

  property p_prescale_hold;
    @(posedge pclk) disable iff (!presetn)
      ((mode == GPT_MODE_CAPTURE) || (mode == GPT_MODE_REFERENCE)) && (pre_cnt != prescale)
        |=> (count == $past(count));
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) else $error("prescaler divided wrongly");

  property p_prescale_tick;
    @(posedge pclk) disable iff (!presetn)
      ((mode == GPT_MODE_CAPTURE) || (mode == GPT_MODE_REFERENCE)) && src_tick && (pre_cnt == prescale)
        |=> (count == $past(count) + 16'h0001);
  endproperty
  a_prescale_tick: assert property (p_prescale_tick) else $error("prescaler tick did not advance counter");

  c_capture: cover property (@(posedge pclk) disable iff (!presetn) capture_pulse);
  c_ref_out: cover property (@(posedge pclk) disable iff (!presetn) $fell(timer_out));
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) advance && (count == 16'hFFFF));

endmodule // gpt_timer

// ===== gpt_top.sv
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
module gpt_top import gpt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] external_timer_clock_in,
  input wire logic [1:0] ext_event,
  output logic [1:0] timer_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_timer_reg(input logic [7:0] addr, input int idx, input logic [7:0] off);
    return addr == (GPT_TIMER_STRIDE * 8'(idx)) + off;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = (addr == GPT_OFF_IRQ_STATUS) || (addr == GPT_OFF_IRQ_ENABLE) || (addr == GPT_OFF_IRQ_CLEAR);
    for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
      hit = hit || is_timer_reg(addr, i, GPT_OFF_CTRL) || is_timer_reg(addr, i, GPT_OFF_REF)
        || is_timer_reg(addr, i, GPT_OFF_CAPTURE) || is_timer_reg(addr, i, GPT_OFF_COUNT);
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] ctrl [GPT_NUM_TIMERS];
  logic [15:0] ref_value [GPT_NUM_TIMERS];
  logic [15:0] count [GPT_NUM_TIMERS];
  logic [15:0] capture [GPT_NUM_TIMERS];
  logic [GPT_ST_WIDTH-1:0] irq_status;
  logic [GPT_ST_WIDTH-1:0] irq_enable;
  logic [GPT_ST_WIDTH-1:0] status_set;
  logic [GPT_ST_WIDTH-1:0] status_clr;
  logic [1:0] timer_out_int;
  logic setup;
  logic wr_en;
  logic [31:0] next_prdata;

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Zero-wait slave: pready rises in the access phase one edge after setup
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !is_mapped(paddr);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
        ctrl[i] <= GPT_CTRL_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
        if (is_timer_reg(paddr, i, GPT_OFF_CTRL)) begin
          ctrl[i] <= pwdata[15:0];
        end
      end
    end
  end

  // All ones at reset, so a fresh timer only matches at its top count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
        ref_value[i] <= GPT_REF_RESET;
      end
    end else if (wr_en) begin
      for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
        if (is_timer_reg(paddr, i, GPT_OFF_REF)) begin
          ref_value[i] <= pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= '0;
    end else if (wr_en && (paddr == GPT_OFF_IRQ_ENABLE)) begin
      irq_enable <= pwdata[GPT_ST_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle so prdata is a flop
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    for (int i = 0; i < GPT_NUM_TIMERS; i++) begin
      if (is_timer_reg(paddr, i, GPT_OFF_CTRL)) begin
        next_prdata = {16'h0000, ctrl[i]};
      end
      if (is_timer_reg(paddr, i, GPT_OFF_REF)) begin
        next_prdata = {16'h0000, ref_value[i]};
      end
      if (is_timer_reg(paddr, i, GPT_OFF_CAPTURE)) begin
        next_prdata = {16'h0000, capture[i]};
      end
      if (is_timer_reg(paddr, i, GPT_OFF_COUNT)) begin
        next_prdata = {16'h0000, count[i]};
      end
    end
    if (paddr == GPT_OFF_IRQ_STATUS) begin
      next_prdata = {28'h000_0000, irq_status};
    end
    if (paddr == GPT_OFF_IRQ_ENABLE) begin
      next_prdata = {28'h000_0000, irq_enable};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Timer instances
  // ----------------------------------------------------------------
  for (genvar g = 0; g < GPT_NUM_TIMERS; g++) begin : g_timer
    gpt_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .mode(gpt_mode_e'(ctrl[g][GPT_CTRL_MODE_LSB +: 2])),
      .clk_sel(ctrl[g][GPT_CTRL_CLK_SEL]),
      .ref_irq_sel(ctrl[g][GPT_CTRL_REF_IRQ]),
      .out_toggle(ctrl[g][GPT_CTRL_TOGGLE]),
      .edge_sel(ctrl[g][GPT_CTRL_EDGE_LSB +: 2]),
      .prescale(ctrl[g][GPT_CTRL_PRESCALE_LSB +: 8]),
      .ref_value(ref_value[g]),
      .external_timer_clock_in(external_timer_clock_in[g]),
      .ext_event(ext_event[g]),
      .count(count[g]),
      .capture(capture[g]),
      .capture_pulse(status_set[g*GPT_ST_PER_TIMER + GPT_ST_CAPTURE]),
      .ref_irq_pulse(status_set[g*GPT_ST_PER_TIMER + GPT_ST_REF]),
      .timer_out(timer_out_int[g])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  // A clear in the same cycle as a new event leaves the bit set, so no event is lost
  assign status_clr = (wr_en && (paddr == GPT_OFF_IRQ_CLEAR)) ? pwdata[GPT_ST_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      timer_out <= 2'b11;
    end else begin
      irq <= |(irq_status & irq_enable);
      timer_out <= timer_out_int;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle after setup");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      (|status_set) |=> ((irq_status & $past(status_set)) == $past(status_set));
  endproperty
  a_sticky: assert property (p_sticky) else $error("event lost in status register");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      (|(irq_status & irq_enable)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_ref_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && is_timer_reg(paddr, 1, GPT_OFF_REF)) |=> (ref_value[1] == $past(pwdata[15:0]));
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference value not written");

  property p_pin_follow;
    @(posedge pclk) disable iff (!presetn)
      $fell(timer_out_int[1]) |=> !timer_out[1];
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("output pin did not follow timer");

  property p_pready_quiet;
    @(posedge pclk) disable iff (!presetn)
      !(psel && !penable) |=> !pready;
  endproperty
  a_pready_quiet: assert property (p_pready_quiet) else $error("pready without a setup cycle");

  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && !is_mapped(paddr)) |=> pready && pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped read not refused");

  property p_mapped_ok;
    @(posedge pclk) disable iff (!presetn)
      (setup && is_mapped(paddr)) |=> pready && !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access flagged as error");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && (paddr == GPT_OFF_IRQ_STATUS)) |=> (prdata == {28'h000_0000, $past(irq_status)});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read back wrong");

  property p_capture_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && is_timer_reg(paddr, 0, GPT_OFF_CAPTURE)) |=> (prdata == {16'h0000, $past(capture[0])});
  endproperty
  a_capture_read: assert property (p_capture_read) else $error("capture read back wrong");

  property p_ref_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && is_timer_reg(paddr, 1, GPT_OFF_REF)) |=> (prdata == {16'h0000, $past(ref_value[1])});
  endproperty
  a_ref_read: assert property (p_ref_read) else $error("reference read back wrong");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && (paddr == GPT_OFF_IRQ_CLEAR) && (status_set == '0))
        |=> ((irq_status & $past(pwdata[GPT_ST_WIDTH-1:0])) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("status bit not cleared");

  property p_irq_quiet;
    @(posedge pclk) disable iff (!presetn)
      ((irq_status & irq_enable) == '0) |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt raised with nothing pending");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && (paddr == GPT_OFF_IRQ_ENABLE)) |=> (irq_enable == $past(pwdata[GPT_ST_WIDTH-1:0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable word not written");

  // ----------------------------------------------------------------
  // Per-timer register checks
  // ----------------------------------------------------------------
  for (genvar t = 0; t < GPT_NUM_TIMERS; t++) begin : g_chk
    property p_ctrl_write;
      @(posedge pclk) disable iff (!presetn)
        (wr_en && is_timer_reg(paddr, t, GPT_OFF_CTRL)) |=> (ctrl[t] == $past(pwdata[15:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control word not written");

    property p_count_read;
      @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && is_timer_reg(paddr, t, GPT_OFF_COUNT)) |=> (prdata == {16'h0000, $past(count[t])});
    endproperty
    a_count_read: assert property (p_count_read) else $error("counter read back wrong");
  end

  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule // gpt_top

// ===== gpt_far_side.sv
`timescale 1ns/1ns
module gpt_far_side (
  input wire logic pclk,
  input wire logic [1:0] timer_out,
  output logic [1:0] external_timer_clock_in,
  output logic [1:0] ext_event,
  output int low_count
);
  initial begin
    external_timer_clock_in = 2'b00;
    ext_event = 2'b00;
    low_count = 0;
  end
  // Cycles spent low on pin 1, so one-cycle pulses can be counted
  always @(posedge pclk) begin
    if (timer_out[1] === 1'b0) begin
      low_count <= low_count + 1;
    end
  end
  // High one cycle, then low for a random gap: prompt and slow sources both occur
  task automatic pulse(input logic [1:0] clk_m, input logic [1:0] ev_m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      external_timer_clock_in <= clk_m;
      ext_event <= ev_m;
      @(posedge pclk);
      external_timer_clock_in <= 2'b00;
      ext_event <= 2'b00;
      repeat ($urandom_range(2, 0)) @(posedge pclk);
    end
  endtask
endmodule // gpt_far_side

// ===== tb_general_purpose_timer_pair.sv
`timescale 1ns/1ns
module tb_general_purpose_timer_pair import gpt_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ext_clk;
  logic [1:0] ext_event;
  logic [1:0] timer_out;
  logic irq;
  int low_count;
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;
  int p, n, r, st;
  logic [31:0] rdat, c;
  logic err, lv;
  logic [15:0] c0;

  always #20 pclk = ~pclk;

  gpt_top u_gpt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock_in(ext_clk), .ext_event(ext_event), .timer_out(timer_out), .irq(irq));
  gpt_far_side u_gpt_far_side (.pclk(pclk), .timer_out(timer_out), .external_timer_clock_in(ext_clk),
    .ext_event(ext_event), .low_count(low_count));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask
  function automatic logic [7:0] ta(input int k, input logic [7:0] off);
    return 8'(k) * GPT_TIMER_STRIDE + off;
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic cs, ri, tg, input logic [1:0] eg,
                                      input logic [7:0] pre);
    return 32'(m) | (32'(cs) << GPT_CTRL_CLK_SEL) | (32'(ri) << GPT_CTRL_REF_IRQ) |
      (32'(tg) << GPT_CTRL_TOGGLE) | (32'(eg) << GPT_CTRL_EDGE_LSB) | (32'(pre) << GPT_CTRL_PRESCALE_LSB);
  endfunction

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Counts reading the same phase of the prescaler give an exact delta
  task automatic delta(input int k, input int gap, input int exp);
    apb(1'b0, ta(k, GPT_OFF_COUNT), 32'h0000_0000);
    c0 = rdat[15:0];
    repeat (gap) @(posedge pclk);
    apb(1'b0, ta(k, GPT_OFF_COUNT), 32'h0000_0000);
    check(32'(16'(rdat[15:0] - c0)), 32'(exp));
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(60029));
    st = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check(32'(timer_out), 32'h0000_0003);
    rd(ta(0, GPT_OFF_CTRL), 32'h0000_0000);
    rd(ta(1, GPT_OFF_REF), 32'h0000_ffff);
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    apb(1'b0, 8'h50, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    check(rdat, 32'h0000_0000);
    $display("reset and map test done");
    p = $urandom_range(7, 0);
    c = ctl(GPT_MODE_CAPTURE, 1'b0, 1'b0, 1'b0, 2'b00, 8'(p));
    apb(1'b1, ta(0, GPT_OFF_CTRL), c);
    rd(ta(0, GPT_OFF_CTRL), c);
    delta(0, 4 * (p + 1) - 3, 4);
    apb(1'b1, ta(1, GPT_OFF_CTRL), ctl(GPT_MODE_CAPTURE, 1'b0, 1'b0, 1'b0, 2'b00, 8'h00));
    delta(1, 65538, 5);
    $display("prescale and wrap test done");
    n = $urandom_range(10, 3);
    apb(1'b1, ta(0, GPT_OFF_CTRL), 32'h0000_0000);
    apb(1'b1, ta(0, GPT_OFF_CTRL), ctl(GPT_MODE_CAPTURE, 1'b1, 1'b0, 1'b0, 2'b01, 8'h00));
    u_gpt_far_side.pulse(2'b01, 2'b00, n);
    repeat (4) @(posedge pclk);
    rd(ta(0, GPT_OFF_COUNT), 32'(n));
    u_gpt_far_side.pulse(2'b00, 2'b01, 1);
    repeat (4) @(posedge pclk);
    st = st | 1;
    rd(ta(0, GPT_OFF_CAPTURE), 32'(n));
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    apb(1'b1, GPT_OFF_IRQ_CLEAR, 32'h0000_0001);
    st = 0;
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    $display("clock source and capture test done");
    for (int eg = 1; eg < 4; eg++) begin
      n = $urandom_range(9, 2);
      apb(1'b1, ta(1, GPT_OFF_CTRL), 32'h0000_0000);
      apb(1'b1, ta(1, GPT_OFF_CTRL), ctl(GPT_MODE_EVENT, 1'b0, 1'b0, 1'b0, 2'(eg), 8'($urandom)));
      u_gpt_far_side.pulse(2'b00, 2'b10, n);
      repeat (4) @(posedge pclk);
      rd(ta(1, GPT_OFF_COUNT), 32'((eg == 3) ? 2 * n : n));
    end
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    $display("event count test done");
    r = $urandom_range(9, 2);
    apb(1'b1, ta(1, GPT_OFF_REF), 32'(r));
    apb(1'b1, GPT_OFF_IRQ_ENABLE, 32'h0000_0000);
    apb(1'b1, ta(1, GPT_OFF_CTRL), 32'h0000_0000);
    apb(1'b1, ta(1, GPT_OFF_CTRL), ctl(GPT_MODE_REFERENCE, 1'b1, 1'b0, 1'b0, 2'b00, 8'h00));
    n = low_count;
    u_gpt_far_side.pulse(2'b10, 2'b00, r - 1);
    repeat (4) @(posedge pclk);
    check(32'(low_count - n), 32'h0000_0000);
    u_gpt_far_side.pulse(2'b10, 2'b00, 1);
    repeat (4) @(posedge pclk);
    check(32'(low_count - n), 32'h0000_0001);
    check(32'(timer_out[1]), 32'h0000_0001);
    apb(1'b1, ta(1, GPT_OFF_CTRL), 32'h0000_0000);
    lv = timer_out[1];
    apb(1'b1, ta(1, GPT_OFF_CTRL), ctl(GPT_MODE_REFERENCE, 1'b1, 1'b0, 1'b1, 2'b00, 8'h00));
    u_gpt_far_side.pulse(2'b10, 2'b00, r);
    repeat (12) @(posedge pclk);
    check(32'(timer_out[1]), {31'h0000_0000, ~lv});
    apb(1'b1, ta(1, GPT_OFF_CTRL), 32'h0000_0000);
    apb(1'b1, ta(1, GPT_OFF_CTRL), ctl(GPT_MODE_REFERENCE, 1'b1, 1'b1, 1'b0, 2'b00, 8'h00));
    n = low_count;
    u_gpt_far_side.pulse(2'b10, 2'b00, r);
    repeat (4) @(posedge pclk);
    st = 8;
    check(32'(timer_out[1]), 32'h0000_0001);
    check(32'(low_count - n), 32'h0000_0000);
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    check(32'(irq), 32'h0000_0000);
    apb(1'b1, GPT_OFF_IRQ_ENABLE, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, GPT_OFF_IRQ_CLEAR, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    st = 0;
    rd(GPT_OFF_IRQ_STATUS, 32'(st));
    check(32'(irq), 32'h0000_0000);
    $display("reference test done");
    print_verdict();
  end
endmodule // tb_general_purpose_timer_pair
